// [ir_host.sv]
`timescale 1ns/1ps
// Host logic in the fabric: put and get each drive one bus cycle just after a rising edge; send drives two.
module ir_host (
    // Clock
    input  wire logic       clk,
    // Register bus
    output logic      [3:0] addr,
    output logic            wr,
    output logic            rd,
    output logic      [7:0] wdata,
    input  wire logic [7:0] rdata
);
    initial begin
        addr = 4'h0;
        wr = 1'b0;
        rd = 1'b0;
        wdata = 8'h00;
    end
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic send(input logic flag, input logic [14:0] cnt);
        put(ir_xcvr_pkg::ADDR_DATA_HI, {flag, cnt[14:8]});
        put(ir_xcvr_pkg::ADDR_DATA_LO, cnt[7:0]);
    endtask
endmodule

// [ir_transceiver_regs.sv]
`timescale 1ns/1ps
// How it works
// - Control at 0001, status at 1011.
// - System frequency write-only; carrier frequency read/write.
// - Data high 1001, low 1010, read/write.
// - Control bit 7 enables the transceiver.
// - Bit 6 picks half or third duty.
// - Bit 5 selects active-low output polarity.
// - Bit 4 stops output after an error.
// - Bit 3 picks fixed or host learning limit.
// - Bit 2 re-measures carrier every ON group.
// - Bits 1:0 select 0/2/4/8 cycle glitch filter.
// - Status bit 7 shows busy.
// - Busy pin equals busy status bit.
// - Status bit 6 shows transfer in progress.
// - Status bit 4 flags frequency counter overflow.
// - Status bit 3 flags cycle counter overflow.
// - Status bit 2 flags under-run or over-run.
// - Status bit 1 flags valid carrier frequency.
// - Status bit 0 buffer ready; bit 5 reserved.
// - Transmit fetch sets buffer ready.
// - Low data write clears buffer ready.
// - Data bit 15 ON flag, 14:0 count.
// - Data error holds until control rewritten or restart.
// - Carrier period is system over carrier frequency.
// - Zero transmit count counts as one.
module ir_transceiver_regs (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Transceiver control bus
    input  wire logic [3:0] xcvr_reg_address,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    input  wire logic [7:0] regWriteData,
    output logic      [7:0] regReadData,
    // Mode select: 1 learns from the input, 0 transmits
    input  wire logic       learnMode,
    // Infrared pins
    input  wire logic       infrared_input,
    output logic            infrared_output,
    // Handshake pins
    output logic            xcvr_busy_pin,
    output logic            ready_pin,
    output logic            errorPin
);
    logic [7:0]  xcvr_control;
    logic [27:0] sysFreq;
    logic [23:0] carrierFreq;
    logic [15:0] cycleData;
    logic [15:0] carrier_period;
    ir_xcvr_pkg::xcvr_state_t state;

    logic busy, transfer_in_progress, freq_counter_overflow, cycle_counter_overflow;
    logic data_run_error, rx_freq_ready, buffer_ready;

    logic xcvr_enable, third_duty_select, output_polarity, stop_output_on_error;
    logic user_max_count, carrier_remeasure_en;
    logic [1:0] input_glitch_filter_sel;

    assign xcvr_enable             = xcvr_control[ir_xcvr_pkg::CTL_ENABLE];
    assign third_duty_select       = xcvr_control[ir_xcvr_pkg::CTL_THIRD];
    assign output_polarity         = xcvr_control[ir_xcvr_pkg::CTL_POLARITY];
    assign stop_output_on_error    = xcvr_control[ir_xcvr_pkg::CTL_STOP_ERR];
    assign user_max_count          = xcvr_control[ir_xcvr_pkg::CTL_USER_MAX];
    assign carrier_remeasure_en    = xcvr_control[ir_xcvr_pkg::CTL_REMEASURE];
    assign input_glitch_filter_sel = xcvr_control[ir_xcvr_pkg::CTL_FILT_HI -: 2];

    logic wrControl, wrDataLo, rdDataLo, rdCarrier0;
    assign wrControl  = regWrite && (xcvr_reg_address == ir_xcvr_pkg::ADDR_CONTROL);
    assign wrDataLo   = regWrite && (xcvr_reg_address == ir_xcvr_pkg::ADDR_DATA_LO);
    assign rdDataLo   = regRead && (xcvr_reg_address == ir_xcvr_pkg::ADDR_DATA_LO);
    assign rdCarrier0 = regRead && (xcvr_reg_address == ir_xcvr_pkg::ADDR_CARF0);

    // Event start: enable rising edge begins a new session.
    logic enableLast, sessionStart;
    assign sessionStart = xcvr_enable && !enableLast;

    // Learning-side and transmit-side (txFetch, txUnderrun) events driven by the datapaths below.
    logic learnWord, learnFreq, learnFreqOvf, learnCycOvf;
    logic [15:0] learnWordValue;
    logic [23:0] learnFreqValue;
    logic txFetch, txUnderrun;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            xcvr_control <= ir_xcvr_pkg::CONTROL_RESET;
            enableLast   <= 1'b0;
        end else begin
            enableLast <= xcvr_enable;
            if (wrControl) begin
                xcvr_control <= regWriteData;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sysFreq     <= ir_xcvr_pkg::SYS_FREQ_RESET;
            carrierFreq <= ir_xcvr_pkg::CAR_FREQ_RESET;
        end else begin
            if (regWrite) begin
                unique case (xcvr_reg_address)
                    ir_xcvr_pkg::ADDR_SYSF3: sysFreq[27:24]     <= regWriteData[3:0];
                    ir_xcvr_pkg::ADDR_SYSF2: sysFreq[23:16]     <= regWriteData;
                    ir_xcvr_pkg::ADDR_SYSF1: sysFreq[15:8]      <= regWriteData;
                    ir_xcvr_pkg::ADDR_SYSF0: sysFreq[7:0]       <= regWriteData;
                    ir_xcvr_pkg::ADDR_CARF2: carrierFreq[23:16] <= regWriteData;
                    ir_xcvr_pkg::ADDR_CARF1: carrierFreq[15:8]  <= regWriteData;
                    ir_xcvr_pkg::ADDR_CARF0: carrierFreq[7:0]   <= regWriteData;
                    default: ;
                endcase
            end else if (learnFreq) begin
                carrierFreq <= learnFreqValue;
            end
        end
    end

    // data bytes, host writes or learned words
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cycleData <= 16'h0000;
        end else if (regWrite && xcvr_reg_address == ir_xcvr_pkg::ADDR_DATA_HI) begin
            cycleData[15:8] <= regWriteData;
        end else if (wrDataLo) begin
            cycleData[7:0] <= regWriteData;
        end else if (learnWord) begin
            cycleData <= learnWordValue;
        end
    end

    logic divStart, divBusy, divDone;
    logic [15:0] divQuot;
    period_divider #(
        .NUM_W(ir_xcvr_pkg::SYS_FREQ_W),
        .DEN_W(ir_xcvr_pkg::CAR_FREQ_W),
        .Q_W  (ir_xcvr_pkg::PERIOD_W)
    ) u_div (
        .clk     (clk),
        .nrst    (nrst),
        .start   (divStart),
        .dividend(sysFreq),
        .divisor (carrierFreq),
        .busy    (divBusy),
        .done    (divDone),
        .quotient(divQuot)
    );
    assign divStart = (state == ir_xcvr_pkg::S_CALC) && !divBusy && !divDone;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            carrier_period <= 16'h0002;
        end else if (divDone) begin
            carrier_period <= (divQuot < 16'h0002) ? 16'h0002 : divQuot;
        end
    end

    // Transmit datapath.
    logic [15:0] carrierCnt;
    logic [14:0] cyclesLeft;
    logic        sendOn, carrierHigh, cycleEnd;
    logic [15:0] onWidth;
    assign onWidth  = third_duty_select ? (carrier_period / 16'h0003) : (carrier_period >> 1);
    assign cycleEnd = (carrierCnt == carrier_period - 16'h0001);

    always_ff @(posedge clk) begin
        if (!nrst || !xcvr_enable) begin
            state      <= ir_xcvr_pkg::S_IDLE;
            carrierCnt <= 16'h0000;
            cyclesLeft <= 15'h0000;
            sendOn     <= 1'b0;
        end else begin
            unique case (state)
                ir_xcvr_pkg::S_IDLE: begin
                    state <= ir_xcvr_pkg::S_CALC;
                end
                ir_xcvr_pkg::S_CALC: begin
                    if (divDone) begin
                        state <= learnMode ? ir_xcvr_pkg::S_LEARN : ir_xcvr_pkg::S_FETCH;
                    end
                end
                ir_xcvr_pkg::S_FETCH: begin
                    sendOn     <= cycleData[ir_xcvr_pkg::DATA_FLAG_BIT];
                    cyclesLeft <= (cycleData[14:0] == 15'h0000) ? 15'h0001 : cycleData[14:0];
                    carrierCnt <= 16'h0000;
                    state      <= ir_xcvr_pkg::S_SEND;
                end
                ir_xcvr_pkg::S_SEND: begin
                    carrierCnt <= cycleEnd ? 16'h0000 : carrierCnt + 16'h0001;
                    if (cycleEnd) begin
                        cyclesLeft <= cyclesLeft - 15'h0001;
                        if (cyclesLeft == 15'h0001) begin
                            state <= ir_xcvr_pkg::S_FETCH;
                        end
                    end
                end
                ir_xcvr_pkg::S_LEARN: begin
                    carrierCnt <= cycleEnd ? 16'h0000 : carrierCnt + 16'h0001;
                end
                default: state <= ir_xcvr_pkg::S_IDLE;
            endcase
        end
    end

    assign txFetch    = (state == ir_xcvr_pkg::S_FETCH);
    // Fetching while the host has not refilled the buffer is an under-run.
    assign txUnderrun = txFetch && buffer_ready && !wrDataLo;
    assign carrierHigh = (state == ir_xcvr_pkg::S_SEND) && sendOn && (carrierCnt < onWidth);

    // Learning datapath: filter, edge detection, period and group counting.
    logic [7:0] inHist;
    logic       inFiltered, inLast, riseEdge, groupOn, freqMeasured;
    logic [15:0] riseGap, lowRun;
    logic [14:0] groupCount, learnLimit;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            inHist     <= 8'h00;
            inFiltered <= 1'b0;
            inLast     <= 1'b0;
        end else begin
            inLast <= inFiltered;
            inHist <= {inHist[6:0], infrared_input};
            unique case (input_glitch_filter_sel)
                2'b00: inFiltered <= infrared_input;
                2'b01: if (&inHist[1:0] || ~|inHist[1:0]) inFiltered <= inHist[0];
                2'b10: if (&inHist[3:0] || ~|inHist[3:0]) inFiltered <= inHist[0];
                2'b11: if (&inHist || ~|inHist) inFiltered <= inHist[0];
            endcase
        end
    end

    assign riseEdge = inFiltered && !inLast;
    assign learnLimit = user_max_count ? cycleData[14:0] : ir_xcvr_pkg::LEARN_MAX;

    always_ff @(posedge clk) begin
        if (!nrst || state != ir_xcvr_pkg::S_LEARN) begin
            riseGap        <= 16'h0000;
            lowRun         <= 16'h0000;
            groupOn        <= 1'b0;
            groupCount     <= 15'h0000;
            freqMeasured   <= 1'b0;
            learnWord      <= 1'b0;
            learnWordValue <= 16'h0000;
            learnFreq      <= 1'b0;
            learnFreqValue <= 24'h000000;
            learnFreqOvf   <= 1'b0;
            learnCycOvf    <= 1'b0;
        end else begin
            learnWord    <= 1'b0;
            learnFreq    <= 1'b0;
            learnFreqOvf <= 1'b0;
            learnCycOvf  <= 1'b0;
            lowRun       <= riseEdge ? 16'h0000 : lowRun + 16'h0001;
            if (riseEdge) begin
                riseGap <= 16'h0001;
            end else if (riseGap == ir_xcvr_pkg::FREQ_CNT_MAX) begin
                riseGap      <= 16'h0000;
                learnFreqOvf <= 1'b1;
            end else if (riseGap != 16'h0000) begin
                riseGap <= riseGap + 16'h0001;
            end
            if (riseEdge && groupOn && groupCount == 15'h0001 && riseGap != 16'h0000 &&
                (!freqMeasured || carrier_remeasure_en)) begin
                learnFreq      <= 1'b1;
                learnFreqValue <= 24'(sysFreq / {12'h000, riseGap});
                freqMeasured   <= 1'b1;
            end
            if (riseEdge && !groupOn) begin
                learnWord      <= groupCount != 15'h0000;
                learnWordValue <= {1'b0, groupCount};
                groupOn        <= 1'b1;
                groupCount     <= 15'h0001;
            end else if (riseEdge) begin
                groupCount <= groupCount + 15'h0001;
            end else if (groupOn && lowRun == carrier_period + carrier_period) begin
                learnWord      <= 1'b1;
                learnWordValue <= {1'b1, groupCount};
                groupOn        <= 1'b0;
                groupCount     <= 15'h0002;
            end else if (!groupOn && lowRun >= carrier_period && cycleEnd) begin
                groupCount <= groupCount + 15'h0001;
            end
            if (groupCount >= learnLimit && learnLimit != 15'h0000) begin
                learnCycOvf    <= 1'b1;
                learnWord      <= 1'b1;
                learnWordValue <= {groupOn, groupCount};
                groupCount     <= 15'h0000;
            end
        end
    end

    // Status flags: set wins over every clear.
    logic clearAll;
    assign clearAll = wrControl || sessionStart;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            freq_counter_overflow  <= 1'b0;
            cycle_counter_overflow <= 1'b0;
            data_run_error         <= 1'b0;
            rx_freq_ready          <= 1'b0;
            buffer_ready           <= 1'b0;
        end else begin
            freq_counter_overflow  <= learnFreqOvf || (freq_counter_overflow && !clearAll);
            cycle_counter_overflow <= learnCycOvf || (cycle_counter_overflow && !clearAll);
            data_run_error <= txUnderrun || (learnWord && buffer_ready) || (data_run_error && !clearAll);
            rx_freq_ready <= learnFreq || (rx_freq_ready && !(clearAll || rdCarrier0));
            // fetch sets ready; low data access clears
            buffer_ready <= txFetch || learnWord ||
                            (buffer_ready && !(clearAll || wrDataLo || rdDataLo));
        end
    end

    assign transfer_in_progress = (state == ir_xcvr_pkg::S_SEND) || (state == ir_xcvr_pkg::S_LEARN);
    assign busy = transfer_in_progress || (state == ir_xcvr_pkg::S_CALC) || (state == ir_xcvr_pkg::S_FETCH);
    assign xcvr_busy_pin = busy;
    assign ready_pin     = buffer_ready;
    assign errorPin      = data_run_error;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            infrared_output <= 1'b0;
        end else begin
            infrared_output <= (carrierHigh && !(stop_output_on_error && data_run_error)) ^ output_polarity;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            regReadData <= 8'h00;
        end else begin
            unique case (xcvr_reg_address)
                ir_xcvr_pkg::ADDR_CARF2:   regReadData <= carrierFreq[23:16];
                ir_xcvr_pkg::ADDR_CARF1:   regReadData <= carrierFreq[15:8];
                ir_xcvr_pkg::ADDR_CARF0:   regReadData <= carrierFreq[7:0];
                ir_xcvr_pkg::ADDR_DATA_HI: regReadData <= cycleData[15:8];
                ir_xcvr_pkg::ADDR_DATA_LO: regReadData <= cycleData[7:0];
                ir_xcvr_pkg::ADDR_STATUS:  regReadData <= {busy, transfer_in_progress, 1'b0,
                                                           freq_counter_overflow, cycle_counter_overflow,
                                                           data_run_error, rx_freq_ready, buffer_ready};
                default:                   regReadData <= 8'h00;
            endcase
        end
    end
endmodule

// [ir_xcvr_asserts.sv]
`timescale 1ns/1ps
module ir_xcvr_asserts (
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Register bus
    input wire logic [3:0] xcvr_reg_address,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regWriteData,
    input wire logic [7:0] regReadData,
    // Pins
    input wire logic       learnMode,
    input wire logic       infrared_input,
    input wire logic       infrared_output,
    input wire logic       xcvr_busy_pin,
    input wire logic       ready_pin,
    input wire logic       errorPin
);
    logic ctlWr;
    logic ctlEn;
    assign ctlWr = regWrite && xcvr_reg_address == ir_xcvr_pkg::ADDR_CONTROL;
    always_ff @(posedge clk) begin
        if (!nrst) begin
            ctlEn <= 1'b0;
        end else if (ctlWr) begin
            ctlEn <= regWriteData[7];
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence enableRise;
        ctlWr && regWriteData[7] && !ctlEn;
    endsequence
    sequence busySoon;
        ##[1:3] xcvr_busy_pin;
    endsequence
    reset_clears_a: assert property (disable iff (1'b0) !nrst |=>
        regReadData == 8'h00 && !xcvr_busy_pin && !ready_pin && !errorPin && !infrared_output)
        else $error("reset left an output set");
    enable_start_a: assert property (enableRise |-> busySoon)
        else $error("enable did not start a session");
    disable_idle_a: assert property (ctlWr && !regWriteData[7] |-> ##[1:2] !xcvr_busy_pin)
        else $error("disable did not return to idle");
    unmapped_zero_a: assert property (xcvr_reg_address <= 4'h5 || xcvr_reg_address >= 4'hc |=> regReadData == 8'h00)
        else $error("unreadable address returned data");
    status_mirror_a: assert property (xcvr_reg_address == ir_xcvr_pkg::ADDR_STATUS |=>
        regReadData[7] == $past(xcvr_busy_pin) && regReadData[0] == $past(ready_pin)
        && regReadData[2] == $past(errorPin) && !regReadData[5]) else $error("status and pins disagree");
    progress_busy_a: assert property (xcvr_reg_address == ir_xcvr_pkg::ADDR_STATUS |=> !regReadData[6] || regReadData[7])
        else $error("transfer flag without busy");
    lo_clear_a: assert property (regWrite && xcvr_reg_address == ir_xcvr_pkg::ADDR_DATA_LO && !learnMode
        |=> !ready_pin || errorPin) else $error("low data write left ready set");
    error_hold_a: assert property (errorPin && !ctlWr |=> errorPin)
        else $error("error flag dropped early");
endmodule
bind ir_transceiver_regs ir_xcvr_asserts chk (.clk, .nrst, .xcvr_reg_address, .regWrite, .regRead, .regWriteData,
    .regReadData, .learnMode, .infrared_input, .infrared_output, .xcvr_busy_pin, .ready_pin, .errorPin);

// [ir_xcvr_pkg.sv]
package ir_xcvr_pkg;
    localparam logic [3:0] ADDR_CONTROL  = 4'h1;
    localparam logic [3:0] ADDR_SYSF3    = 4'h2;
    localparam logic [3:0] ADDR_SYSF2    = 4'h3;
    localparam logic [3:0] ADDR_SYSF1    = 4'h4;
    localparam logic [3:0] ADDR_SYSF0    = 4'h5;
    localparam logic [3:0] ADDR_CARF2    = 4'h6;
    localparam logic [3:0] ADDR_CARF1    = 4'h7;
    localparam logic [3:0] ADDR_CARF0    = 4'h8;
    localparam logic [3:0] ADDR_DATA_HI  = 4'h9;
    localparam logic [3:0] ADDR_DATA_LO  = 4'ha;
    localparam logic [3:0] ADDR_STATUS   = 4'hb;

    localparam int CTL_ENABLE    = 7;
    localparam int CTL_THIRD     = 6;
    localparam int CTL_POLARITY  = 5;
    localparam int CTL_STOP_ERR  = 4;
    localparam int CTL_USER_MAX  = 3;
    localparam int CTL_REMEASURE = 2;
    localparam int CTL_FILT_HI   = 1;

    localparam int ST_BUSY      = 7;
    localparam int ST_XFER      = 6;
    localparam int ST_FREQ_OVF  = 4;
    localparam int ST_CYC_OVF   = 3;
    localparam int ST_DATA_ERR  = 2;
    localparam int ST_FREQ_RDY  = 1;
    localparam int ST_BUF_RDY   = 0;

    localparam int DATA_FLAG_BIT = 15;
    localparam int SYS_FREQ_W    = 28;
    localparam int CAR_FREQ_W    = 24;
    localparam int PERIOD_W      = 16;
    localparam int COUNT_W       = 15;

    localparam logic [7:0]  CONTROL_RESET = 8'h00;
    localparam logic [14:0] LEARN_MAX     = 15'h7fff;
    localparam logic [15:0] FREQ_CNT_MAX  = 16'hffff;
    localparam logic [27:0] SYS_FREQ_RESET = 28'h5f5e100;
    localparam logic [23:0] CAR_FREQ_RESET = 24'h009470;

    typedef enum logic [2:0] {
        S_IDLE   = 3'b000,
        S_CALC   = 3'b001,
        S_FETCH  = 3'b010,
        S_SEND   = 3'b011,
        S_LEARN  = 3'b100
    } xcvr_state_t;
endpackage

// [period_divider.sv]
`timescale 1ns/1ps
// Serial restoring divider: quotient = dividend / divisor, one bit per cycle.
module period_divider #(
    parameter int NUM_W = 28,
    parameter int DEN_W = 24,
    parameter int Q_W   = 16
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             nrst,
    // Request
    input  wire logic             start,
    input  wire logic [NUM_W-1:0] dividend,
    input  wire logic [DEN_W-1:0] divisor,
    // Result
    output logic                  busy,
    output logic                  done,
    output logic [Q_W-1:0]        quotient
);
    logic [NUM_W-1:0] quo;
    logic [NUM_W:0]   rem;
    logic [DEN_W-1:0] den;
    logic [5:0]       bitsLeft;
    logic [NUM_W:0]   trial;

    always_comb begin
        trial = {rem[NUM_W-1:0], quo[NUM_W-1]};
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            quo      <= '0;
            rem      <= '0;
            den      <= '0;
            bitsLeft <= 6'h00;
            busy     <= 1'b0;
            done     <= 1'b0;
            quotient <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                quo      <= dividend;
                rem      <= '0;
                den      <= (divisor == '0) ? DEN_W'(1) : divisor;
                bitsLeft <= 6'(NUM_W);
                busy     <= 1'b1;
            end else if (busy) begin
                if (trial >= {{(NUM_W + 1 - DEN_W){1'b0}}, den}) begin
                    rem <= trial - {{(NUM_W + 1 - DEN_W){1'b0}}, den};
                    quo <= {quo[NUM_W-2:0], 1'b1};
                end else begin
                    rem <= trial;
                    quo <= {quo[NUM_W-2:0], 1'b0};
                end
                bitsLeft <= bitsLeft - 6'h01;
                if (bitsLeft == 6'h01) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                    // Saturate so an out-of-range ratio still yields a usable period.
                    if (quo[NUM_W-2:Q_W-1] != '0) begin
                        quotient <= '1;
                    end else begin
                        quotient <= {quo[Q_W-2:0], (trial >= {{(NUM_W + 1 - DEN_W){1'b0}}, den})};
                    end
                end
            end
        end
    end
endmodule

// [test_ir_transceiver_regs.sv]
`timescale 1ns/1ps
`define CHECK(g, e) begin compares++; if ((g) !== (e)) begin failures++; $display("wrong value at %0t: %h %h", $time, g, e); end end
module test_ir_transceiver_regs;
    logic       clk = 1'b0;
    logic       nrst;
    logic [3:0] addr;
    logic       regWrite;
    logic       regRead;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic       learnMode;
    logic       irIn = 1'b0;
    logic       irOut;
    logic       busy;
    logic       ready;
    logic       err;
    logic       carrierOn = 1'b0;
    logic [1:0] ph = 2'b00;
    logic [7:0] r;
    logic [7:0] cfg [7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h08};
    integer     failures = 0;
    integer     compares = 0;
    integer     seed = 32'h97695cf8;
    logic [7:0] v;
    logic       third = 1'b0;
    logic       watchOut = 1'b0;
    int         hiRun = 0;
    ir_transceiver_regs DUT (.clk(clk), .nrst(nrst), .xcvr_reg_address(addr), .regWrite(regWrite),
        .regRead(regRead), .regWriteData(wdata), .regReadData(rdata), .learnMode(learnMode),
        .infrared_input(irIn), .infrared_output(irOut), .xcvr_busy_pin(busy), .ready_pin(ready), .errorPin(err));
    ir_host host (.clk(clk), .addr(addr), .wr(regWrite), .rd(regRead), .wdata(wdata), .rdata(rdata));
    always #5 clk = ~clk;
    // Received carrier of eight clocks per period, low between bursts.
    always @(posedge clk) begin
        ph <= ph + 2'd1;
        irIn <= carrierOn && (irIn ^ (ph == 2'd3));
    end
    // Each transmitted ON pulse lasts the selected share of the 8-clock carrier period.
    always @(posedge clk) begin
        if (watchOut && irOut === 1'b1) begin
            hiRun <= hiRun + 1;
        end else begin
            if (watchOut && hiRun != 0) `CHECK(hiRun, third ? 8 / 3 : 8 / 2)
            hiRun <= 0;
        end
    end
    function automatic logic [7:0] freqByte0(input int sysHz, input int per);
        return 8'(sysHz / per);
    endfunction
    task automatic results();
        if (failures == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic waitSig(input logic onErr);
        @(posedge clk);
        #1;
        for (int i = 0; i < 3000 && (onErr ? err : ready) !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        `CHECK(onErr ? err : ready, 1'b1)
    endtask
    initial begin
        #200000;
        failures++;
        results();
    end
    initial begin
        nrst = 1'b0;
        learnMode = 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        for (int a = 6; a <= 10; a++) begin
            v = 8'($random(seed));
            host.put(a[3:0], v);
            host.get(a[3:0], r);
            `CHECK(r, v)
        end
        host.put(ir_xcvr_pkg::ADDR_STATUS, 8'($random(seed)));
        for (int a = 2; a <= 8; a++) host.put(a[3:0], cfg[a-2]);
        for (int a = 0; a < 16; a++) begin
            if (a >= 6 && a <= 10) continue;
            host.get(a[3:0], r);
            `CHECK(r, 8'h00)
        end
        host.put(ir_xcvr_pkg::ADDR_CONTROL, 8'h20);
        repeat (4) @(posedge clk);
        #1;
        `CHECK(irOut, 1'b1)
        host.send(1'b1, 15'h0000);
        third = 1'($random(seed));
        host.put(ir_xcvr_pkg::ADDR_CONTROL, {1'b1, third, 6'h10});
        waitSig(1'b0);
        watchOut = 1'b1;
        host.get(ir_xcvr_pkg::ADDR_STATUS, r);
        `CHECK(r[7:6], 2'b11)
        for (int n = 0; n < 6; n++) begin
            host.send(n[0], 15'($random(seed) & 3));
            waitSig(1'b0);
        end
        waitSig(1'b1);
        for (int i = 0; i < 20; i++) begin
            @(posedge clk);
            #1;
            `CHECK(irOut, 1'b0)
        end
        watchOut = 1'b0;
        host.put(ir_xcvr_pkg::ADDR_CONTROL, 8'h00);
        host.get(ir_xcvr_pkg::ADDR_STATUS, r);
        `CHECK({r[7], r[2]}, 2'b00)
        learnMode <= 1'b1;
        host.put(ir_xcvr_pkg::ADDR_CONTROL, 8'h80 | 8'($random(seed) & 1));
        carrierOn <= 1'b1;
        repeat (400) @(posedge clk);
        carrierOn <= 1'b0;
        waitSig(1'b0);
        host.get(ir_xcvr_pkg::ADDR_DATA_HI, r);
        `CHECK(r[7], 1'b1)
        host.get(ir_xcvr_pkg::ADDR_STATUS, r);
        `CHECK(r[1], 1'b1)
        host.get(ir_xcvr_pkg::ADDR_CARF0, r);
        `CHECK(r, freqByte0(64, 8))
        host.get(ir_xcvr_pkg::ADDR_STATUS, r);
        `CHECK(r[1], 1'b0)
        results();
    end
endmodule
